// >>> verilog/vout_margin_ovp_cmd_regs.sv
// command register bank: ceiling, margin set-points, current offset, ov response
// assumes: a bus decoder upstream turns host transactions into one-cycle command
// strobes on this clock; analog and telemetry blocks consume the outputs.
`timescale 1ns/10ps
`include "vout_regs_map.svh"
module vout_margin_ovp_cmd_regs
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire vout_regs_pkg::cmd_code_t cmd_code,
  input wire vout_regs_pkg::cmd_word_t cmd_wdata,
  output vout_regs_pkg::cmd_word_t rsp_rdata,
  output logic rsp_valid,
  output logic rsp_error,
  input wire vout_regs_pkg::op_sel_e op_sel,
  input wire vout_regs_pkg::vid_code_t nominal_code,
  input wire logic converter_on_req,
  input wire logic clear_faults,
  input wire logic ov_detect_pin,
  input wire logic ramp_select_strap,
  input wire logic vendor_cfg_valid,
  input wire logic vendor_cfg_protocol_select,
  input wire logic [10:0] iout_raw_mantissa,
  output vout_regs_pkg::vid_code_t voltage_id_code,
  output logic vid_protocol,
  output logic converter_enable,
  output logic [4:0] cal_offset_exponent,
  output logic [10:0] cal_offset_mantissa,
  output logic [10:0] iout_corrected_mantissa,
  output logic stat_byte_ov,
  output logic stat_byte_other,
  output logic stat_word_vout,
  output logic stat_vout_ov,
  output logic stat_output_ceiling_warn,
  output logic host_alert_line_out,
  output logic host_alert_line_oe
);
  import vout_regs_pkg::*;

  vid_code_t ceiling_ff;
  vid_code_t nxt_ceiling;
  vid_code_t margin_high_ff;
  vid_code_t nxt_margin_high;
  vid_code_t margin_low_ff;
  vid_code_t nxt_margin_low;
  cmd_word_t cal_offset_ff;
  cmd_word_t nxt_cal_offset;
  cmd_word_t rdata_ff;
  cmd_word_t nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic rerr_ff;
  logic nxt_rerr;
  logic [`SYNC_STAGES-1:0] strap_sync_ff;
  logic proto_ff;
  logic nxt_proto;
  logic [10:0] iout_ff;
  logic [10:0] nxt_iout;
  logic latched_off;
  logic ceiling_hit;
  logic alert_active;
  logic wr;
  logic rd;
  logic [11:0] sum_ext;
  vid_code_t target_code;

  assign wr = cmd_valid && cmd_write;
  assign rd = cmd_valid && !cmd_write;

  // register writes; only the low byte of code registers is stored
  always_comb
  begin
    nxt_ceiling = ceiling_ff;
    nxt_margin_high = margin_high_ff;
    nxt_margin_low = margin_low_ff;
    nxt_cal_offset = cal_offset_ff;
    if (wr)
    begin
      case (cmd_code)
        `CODE_OUTPUT_CEILING: nxt_ceiling = cmd_wdata[`VID_MSB:`VID_LSB];
        `CODE_MARGIN_HIGH: nxt_margin_high = cmd_wdata[`VID_MSB:`VID_LSB];
        `CODE_MARGIN_LOW: nxt_margin_low = cmd_wdata[`VID_MSB:`VID_LSB];
        `CODE_CAL_OFFSET: nxt_cal_offset = cmd_wdata;
        default: nxt_cal_offset = cal_offset_ff;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ceiling_ff <= `RST_OUTPUT_CEILING;
      margin_high_ff <= `RST_MARGIN_HIGH;
      margin_low_ff <= `RST_MARGIN_LOW;
      cal_offset_ff <= `RST_CAL_OFFSET;
    end
    else
    begin
      ceiling_ff <= nxt_ceiling;
      margin_high_ff <= nxt_margin_high;
      margin_low_ff <= nxt_margin_low;
      cal_offset_ff <= nxt_cal_offset;
    end
  end

  // read data and answer, one cycle after the strobe
  always_comb
  begin
    nxt_rdata = rdata_ff;
    nxt_rvalid = cmd_valid;
    nxt_rerr = 1'b0;
    case (cmd_code)
      `CODE_OUTPUT_CEILING:
        if (rd)
          nxt_rdata = {8'h00, ceiling_ff};
      `CODE_MARGIN_HIGH:
        if (rd)
          nxt_rdata = {8'h00, margin_high_ff};
      `CODE_MARGIN_LOW:
        if (rd)
          nxt_rdata = {8'h00, margin_low_ff};
      `CODE_CAL_OFFSET:
        if (rd)
          nxt_rdata = cal_offset_ff;
      `CODE_OV_RESPONSE:
      begin
        // fixed response; a write is refused and changes nothing
        if (rd)
          nxt_rdata = {8'h00, `RST_OV_RESPONSE};
        nxt_rerr = wr;
      end
      default:
      begin
        if (rd)
          nxt_rdata = 16'h0000;
        nxt_rerr = cmd_valid;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
      rerr_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      rerr_ff <= nxt_rerr;
    end
  end

  // strap is a pin: two flops before use; vendor setting overrides it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      strap_sync_ff <= '0;
    else
      strap_sync_ff <= {strap_sync_ff[0], ramp_select_strap};
  end

  // offset applied to the reading; mantissas share the offset exponent.
  // saturates instead of wrapping so a big offset cannot flip the sign
  always_comb
  begin
    nxt_proto = vendor_cfg_valid ? vendor_cfg_protocol_select : strap_sync_ff[1];
    sum_ext = {iout_raw_mantissa[10], iout_raw_mantissa}
      + {cal_offset_ff[`CAL_MANT_MSB], cal_offset_ff[`CAL_MANT_MSB:`CAL_MANT_LSB]};
    if (sum_ext[11] != sum_ext[10])
      nxt_iout = sum_ext[11] ? 11'h400 : 11'h3ff;
    else
      nxt_iout = sum_ext[10:0];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      proto_ff <= 1'b0;
      iout_ff <= 11'h000;
    end
    else
    begin
      proto_ff <= nxt_proto;
      iout_ff <= nxt_iout;
    end
  end

  vout_target_select u_target
  (
    .clk(clk),
    .reset(reset),
    .op_sel(op_sel),
    .nominal_code(nominal_code),
    .margin_high_code(margin_high_ff),
    .margin_low_code(margin_low_ff),
    .ceiling_code(ceiling_ff),
    .target_code(target_code),
    .ceiling_hit(ceiling_hit)
  );

  ov_fault_latch u_ov
  (
    .clk(clk),
    .reset(reset),
    .ov_detect_pin(ov_detect_pin),
    .ceiling_hit(ceiling_hit),
    .clear_faults(clear_faults),
    .latched_off(latched_off),
    .stat_byte_ov(stat_byte_ov),
    .stat_byte_other(stat_byte_other),
    .stat_word_vout(stat_word_vout),
    .stat_vout_ov(stat_vout_ov),
    .stat_output_ceiling_warn(stat_output_ceiling_warn),
    .alert_active(alert_active)
  );

  assign rsp_rdata = rdata_ff;
  assign rsp_valid = rvalid_ff;
  assign rsp_error = rerr_ff;
  assign voltage_id_code = target_code;
  assign vid_protocol = proto_ff;
  assign converter_enable = converter_on_req && !latched_off;
  assign cal_offset_exponent = cal_offset_ff[`CAL_EXP_MSB:`CAL_EXP_LSB];
  assign cal_offset_mantissa = cal_offset_ff[`CAL_MANT_MSB:`CAL_MANT_LSB];
  assign iout_corrected_mantissa = iout_ff;
  // open-drain, active low: pull low while alerting
  assign host_alert_line_out = 1'b0;
  assign host_alert_line_oe = alert_active;

  a_ceiling_read: assert property (@(posedge clk) disable iff (reset)
    rd && cmd_code == `CODE_OUTPUT_CEILING |=> rsp_rdata == {8'h00, ceiling_ff})
    else $error("ceiling read data wrong");

  a_reserved_ignored: assert property (@(posedge clk) disable iff (reset)
    wr && cmd_code == `CODE_MARGIN_HIGH |=> margin_high_ff == $past(cmd_wdata[7:0]))
    else $error("margin high write not stored as low byte");

  a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    rd && (cmd_code == `CODE_MARGIN_HIGH || cmd_code == `CODE_MARGIN_LOW)
    |=> rsp_rdata[15:8] == 8'h00)
    else $error("reserved byte not zero");

  a_margin_low_used: assert property (@(posedge clk) disable iff (reset)
    op_sel == op_margin_low && margin_low_ff <= ceiling_ff && $stable(margin_low_ff)
    && $stable(ceiling_ff) |=> voltage_id_code == $past(margin_low_ff))
    else $error("low margin code not driven");

  a_margin_high_used: assert property (@(posedge clk) disable iff (reset)
    op_sel == op_margin_high && margin_high_ff <= ceiling_ff && $stable(margin_high_ff)
    && $stable(ceiling_ff) |=> voltage_id_code == $past(margin_high_ff))
    else $error("high margin code not driven");

  a_cal_roundtrip: assert property (@(posedge clk) disable iff (reset)
    wr && cmd_code == `CODE_CAL_OFFSET ##1 rd && cmd_code == `CODE_CAL_OFFSET
    |=> rsp_rdata == $past(cmd_wdata, 2))
    else $error("offset write not read back");

  a_ovresp_fixed: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && cmd_code == `CODE_OV_RESPONSE |=> rsp_valid
    && (rsp_error ? 1'b1 : rsp_rdata == 16'h0080))
    else $error("ov response not fixed");

  a_ov_latch_off: assert property (@(posedge clk) disable iff (reset)
    $rose(ov_detect_pin) && !clear_faults ##1 !clear_faults ##1 !clear_faults
    |=> !converter_enable)
    else $error("ov did not latch converter off");

  a_latch_holds: assert property (@(posedge clk) disable iff (reset)
    latched_off && !clear_faults |=> latched_off)
    else $error("ov latch released without clear");

  a_ov_status: assert property (@(posedge clk) disable iff (reset)
    latched_off && !$past(latched_off) |-> stat_byte_ov && stat_word_vout
    && stat_vout_ov && host_alert_line_oe)
    else $error("ov status bits missing");

  a_clamp_warn: assert property (@(posedge clk) disable iff (reset)
    ceiling_hit |-> voltage_id_code == $past(ceiling_ff) ##1 stat_output_ceiling_warn
    && stat_byte_other && host_alert_line_oe)
    else $error("over-ceiling not clamped and flagged");

  a_proto_select: assert property (@(posedge clk) disable iff (reset)
    vendor_cfg_valid |=> vid_protocol == $past(vendor_cfg_protocol_select))
    else $error("vendor protocol not selected");
endmodule

// >>> verilog/vout_regs_map.svh
// command codes, field positions, reset values of the vout margin/ovp command registers
// assumes: included by the design modules by bare name
`ifndef VOUT_REGS_MAP_SVH
`define VOUT_REGS_MAP_SVH

`define CODE_OUTPUT_CEILING 8'h24
`define CODE_MARGIN_HIGH 8'h25
`define CODE_MARGIN_LOW 8'h26
`define CODE_CAL_OFFSET 8'h39
`define CODE_OV_RESPONSE 8'h41

`define VID_MSB 7
`define VID_LSB 0
`define CAL_EXP_MSB 15
`define CAL_EXP_LSB 11
`define CAL_MANT_MSB 10
`define CAL_MANT_LSB 0

`define RST_OUTPUT_CEILING 8'hff
`define RST_MARGIN_HIGH 8'h00
`define RST_MARGIN_LOW 8'h00
`define RST_CAL_OFFSET 16'h0000
`define RST_OV_RESPONSE 8'h80

`define SYNC_STAGES 2

`endif

// >>> verilog/vout_regs_pkg.sv
// types shared by the vout margin/ovp command register modules
// assumes: constants live in vout_regs_map.svh
package vout_regs_pkg;
  typedef logic [7:0] vid_code_t;
  typedef logic [7:0] cmd_code_t;
  typedef logic [15:0] cmd_word_t;

  // operation command selection, one-hot
  typedef enum logic [2:0]
  {
    op_nominal = 3'b001,
    op_margin_low = 3'b010,
    op_margin_high = 3'b100
  } op_sel_e;

  // overvoltage latch state, one-hot
  typedef enum logic [1:0]
  {
    ov_run = 2'b01,
    ov_latched = 2'b10
  } ov_state_e;
endpackage

// >>> verilog/vout_target_select.sv
// picks the output code from nominal/margin set-points and clamps it to the ceiling
// assumes: same clock and reset as the register bank; inputs are synchronous
`timescale 1ns/10ps
`include "vout_regs_map.svh"
module vout_target_select
(
  input wire logic clk,
  input wire logic reset,
  input wire vout_regs_pkg::op_sel_e op_sel,
  input wire vout_regs_pkg::vid_code_t nominal_code,
  input wire vout_regs_pkg::vid_code_t margin_high_code,
  input wire vout_regs_pkg::vid_code_t margin_low_code,
  input wire vout_regs_pkg::vid_code_t ceiling_code,
  output vout_regs_pkg::vid_code_t target_code,
  output logic ceiling_hit
);
  import vout_regs_pkg::*;

  vid_code_t target_ff;
  vid_code_t nxt_target;
  logic hit_ff;
  logic nxt_hit;
  vid_code_t wanted;

  always_comb
  begin
    case (op_sel)
      op_margin_high: wanted = margin_high_code;
      op_margin_low: wanted = margin_low_code;
      op_nominal: wanted = nominal_code;
      default: wanted = nominal_code;
    endcase
    // over-ceiling is a warning only: clamp and flag
    nxt_hit = (wanted > ceiling_code);
    nxt_target = nxt_hit ? ceiling_code : wanted;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      target_ff <= `RST_MARGIN_LOW;
      hit_ff <= 1'b0;
    end
    else
    begin
      target_ff <= nxt_target;
      hit_ff <= nxt_hit;
    end
  end

  assign target_code = target_ff;
  assign ceiling_hit = hit_ff;
endmodule

// >>> verilog/ov_fault_latch.sv
// overvoltage latch-off and sticky status/alert bits
// assumes: ov_detect_pin is asynchronous; clear_faults is a same-clock pulse
`timescale 1ns/10ps
`include "vout_regs_map.svh"
module ov_fault_latch
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ov_detect_pin,
  input wire logic ceiling_hit,
  input wire logic clear_faults,
  output logic latched_off,
  output logic stat_byte_ov,
  output logic stat_byte_other,
  output logic stat_word_vout,
  output logic stat_vout_ov,
  output logic stat_output_ceiling_warn,
  output logic alert_active
);
  import vout_regs_pkg::*;

  logic [`SYNC_STAGES-1:0] ov_sync_ff;
  ov_state_e state_ff;
  ov_state_e nxt_state;
  logic [4:0] stat_ff;
  logic [4:0] nxt_stat;
  logic ov_seen;

  // first stage read only by second stage
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ov_sync_ff <= '0;
    else
      ov_sync_ff <= {ov_sync_ff[0], ov_detect_pin};
  end

  assign ov_seen = ov_sync_ff[1];

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ov_run:
        if (ov_seen)
          nxt_state = ov_latched;
      ov_latched:
        // leaves only on clear, and only once the fault is gone
        if (clear_faults && !ov_seen)
          nxt_state = ov_run;
      default: nxt_state = ov_run;
    endcase
    // bit order: output_ceiling_warn, vout_ov, word_vout, byte_other, byte_ov
    nxt_stat = clear_faults ? 5'h00 : stat_ff;
    // set wins over a clear in the same cycle
    if (ov_seen)
      nxt_stat = nxt_stat | 5'b0_1101;
    if (ceiling_hit)
      nxt_stat = nxt_stat | 5'b1_0010;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= ov_run;
      stat_ff <= 5'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      stat_ff <= nxt_stat;
    end
  end

  assign latched_off = (state_ff == ov_latched);
  assign stat_byte_ov = stat_ff[0];
  assign stat_byte_other = stat_ff[1];
  assign stat_word_vout = stat_ff[2];
  assign stat_vout_ov = stat_ff[3];
  assign stat_output_ceiling_warn = stat_ff[4];
  assign alert_active = |stat_ff;
endmodule

// >>> tb/pmbus_host_model.sv
// host model: sends queued command words to the register bank, one a cycle
// assumes: bank samples on rising edge; commands queued only after reset release
`timescale 1ns/10ps
module pmbus_host_model
(
  input wire logic clk,
  output logic cmd_valid,
  output logic cmd_write,
  output vout_regs_pkg::cmd_code_t cmd_code,
  output vout_regs_pkg::cmd_word_t cmd_wdata
);
  import vout_regs_pkg::*;
  logic [24:0] q[$];
  logic [24:0] c;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // one whole word per command, write flag, code and data applied together
  always @(negedge clk)
  begin
    if (q.size() > 0)
    begin
      c = q.pop_front();
      cmd_valid <= 1'b1;
      {cmd_write, cmd_code, cmd_wdata} <= c;
    end
    else
    begin
      cmd_valid <= 1'b0;
      // idle bus toggles data so stale words are never mistaken for live ones
      cmd_wdata <= ~cmd_wdata;
    end
  end
endmodule

// >>> tb/vout_margin_ovp_cmd_regs_tb.sv
// self-checking bench for the vout margin/ovp command register bank
// assumes: host model drives commands; responses scored from a queue
`timescale 1ns/10ps
module vout_margin_ovp_cmd_regs_tb;
  import vout_regs_pkg::*;
  logic clk, reset, cmd_valid, cmd_write, rsp_valid, rsp_error;
  cmd_code_t cmd_code;
  cmd_word_t cmd_wdata, rsp_rdata, d;
  op_sel_e op_sel;
  vid_code_t nominal_code, voltage_id_code, lo;
  logic converter_on_req, clear_faults, ov_detect_pin, ramp_select_strap;
  logic vendor_cfg_valid, vendor_cfg_protocol_select, vid_protocol, converter_enable;
  logic [10:0] iout_raw_mantissa, cal_offset_mantissa, iout_corrected_mantissa, m;
  logic [4:0] cal_offset_exponent;
  logic stat_byte_ov, stat_byte_other, stat_word_vout, stat_vout_ov, stat_output_ceiling_warn;
  logic host_alert_line_out, host_alert_line_oe;
  logic [17:0] expq[$];
  logic [17:0] e;
  int err_count, checks;

  pmbus_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  vout_margin_ovp_cmd_regs uut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .op_sel(op_sel),
    .nominal_code(nominal_code), .converter_on_req(converter_on_req),
    .clear_faults(clear_faults), .ov_detect_pin(ov_detect_pin),
    .ramp_select_strap(ramp_select_strap), .vendor_cfg_valid(vendor_cfg_valid),
    .vendor_cfg_protocol_select(vendor_cfg_protocol_select),
    .iout_raw_mantissa(iout_raw_mantissa), .voltage_id_code(voltage_id_code),
    .vid_protocol(vid_protocol), .converter_enable(converter_enable),
    .cal_offset_exponent(cal_offset_exponent), .cal_offset_mantissa(cal_offset_mantissa),
    .iout_corrected_mantissa(iout_corrected_mantissa), .stat_byte_ov(stat_byte_ov),
    .stat_byte_other(stat_byte_other), .stat_word_vout(stat_word_vout),
    .stat_vout_ov(stat_vout_ov), .stat_output_ceiling_warn(stat_output_ceiling_warn),
    .host_alert_line_out(host_alert_line_out), .host_alert_line_oe(host_alert_line_oe));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic wr(input cmd_code_t code, input cmd_word_t dat, input logic err);
    host.q.push_back({1'b1, code, dat});
    expq.push_back({1'b0, err, 16'h0000});
  endtask

  // error reads return zero read data; only the flag is scored
  task automatic rd(input cmd_code_t code, input cmd_word_t exp, input logic err);
    host.q.push_back({1'b0, code, 16'h0000});
    expq.push_back({~err, err, exp});
  endtask

  task automatic flush;
    while (host.q.size() > 0)
      @(negedge clk);
    repeat (3) @(negedge clk);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // answer comes exactly one cycle after each command
  always @(negedge clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      e = expq.pop_front();
      chk1(rsp_error, e[16]);
      if (e[17] === 1'b1)
        chk(rsp_rdata, e[15:0]);
    end
  end

  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    reset = 1'b1;
    op_sel = op_nominal;
    nominal_code = 8'h10;
    converter_on_req = 1'b1;
    clear_faults = 1'b0;
    ov_detect_pin = 1'b0;
    ramp_select_strap = 1'b0;
    vendor_cfg_valid = 1'b0;
    vendor_cfg_protocol_select = 1'b0;
    iout_raw_mantissa = 11'h000;
    err_count = 0;
    checks = 0;
    void'($urandom(32'hd8f1));
    repeat (5) @(negedge clk);
    reset = 1'b0;
    rd(8'h24, 16'h00ff, 1'b0);
    rd(8'h25, 16'h0000, 1'b0);
    rd(8'h26, 16'h0000, 1'b0);
    rd(8'h39, 16'h0000, 1'b0);
    rd(8'h41, 16'h0080, 1'b0);
    wr(8'h41, 16'h00ff, 1'b1);
    rd(8'h41, 16'h0080, 1'b0);
    rd(8'h77, 16'h0000, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      // low byte kept at or above the nominal code so no stray ceiling warning
      d = 16'($urandom) | 16'h8010;
      wr(8'h24 + 8'(i), d, 1'b0);
      rd(8'h24 + 8'(i), {8'h00, d[7:0]}, 1'b0);
    end
    lo = 8'($urandom_range(127));
    wr(8'h24, 16'hff80, 1'b0);
    wr(8'h25, 16'h0090, 1'b0);
    wr(8'h26, {8'h00, lo}, 1'b0);
    flush();
    op_sel = op_margin_low;
    repeat (4) @(negedge clk);
    chk(16'(voltage_id_code), 16'(lo));
    chk1(stat_output_ceiling_warn, 1'b0);
    op_sel = op_margin_high;
    repeat (4) @(negedge clk);
    chk(16'(voltage_id_code), 16'h0080);
    chk1(stat_output_ceiling_warn, 1'b1);
    chk1(stat_byte_other, 1'b1);
    chk1(host_alert_line_oe, 1'b1);
    chk1(host_alert_line_out, 1'b0);
    wr(8'h24, 16'h00ff, 1'b0);
    flush();
    chk(16'(voltage_id_code), 16'h0090);
    op_sel = op_nominal;
    clear_faults = 1'b1;
    @(negedge clk);
    clear_faults = 1'b0;
    repeat (3) @(negedge clk);
    chk(16'(voltage_id_code), 16'h0010);
    chk1(host_alert_line_oe, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      {vendor_cfg_valid, vendor_cfg_protocol_select, ramp_select_strap} = 3'(i);
      repeat (4) @(negedge clk);
      chk1(vid_protocol, i[2] ? i[1] : i[0]);
    end
    m = 11'($urandom_range(255));
    d = {5'($urandom), m};
    wr(8'h39, d, 1'b0);
    rd(8'h39, d, 1'b0);
    iout_raw_mantissa = 11'($urandom_range(255));
    flush();
    chk({11'h000, cal_offset_exponent}, {11'h000, d[15:11]});
    chk({5'h00, cal_offset_mantissa}, {5'h00, m});
    chk({5'h00, iout_corrected_mantissa}, {5'h00, iout_raw_mantissa + m});
    ov_detect_pin = 1'b1;
    repeat (4) @(negedge clk);
    chk1(converter_enable, 1'b0);
    chk1(stat_byte_ov, 1'b1);
    chk1(stat_word_vout, 1'b1);
    chk1(stat_vout_ov, 1'b1);
    chk1(host_alert_line_oe, 1'b1);
    ov_detect_pin = 1'b0;
    repeat (6) @(negedge clk);
    chk1(converter_enable, 1'b0);
    clear_faults = 1'b1;
    @(negedge clk);
    clear_faults = 1'b0;
    @(negedge clk);
    chk1(converter_enable, 1'b1);
    chk1(stat_vout_ov, 1'b0);
    rd(8'h41, 16'h0080, 1'b0);
    flush();
    chk(16'(expq.size()), 16'h0000);
    wrap_up();
  end
endmodule
